// >>> verilog/host_bus_pkg.sv
// shared constants and types for the parallel host port control ends
package host_bus_pkg;
    localparam int DATA_W = 8; // host data bus width
    localparam int SYNC_W = DATA_W + 9; // pins passing the device synchroniser
    // position of each pin inside the synchroniser vector
    localparam int SYN_CS = DATA_W + 0;
    localparam int SYN_AS = DATA_W + 1;
    localparam int SYN_RD = DATA_W + 2;
    localparam int SYN_WR = DATA_W + 3;
    localparam int SYN_A0 = DATA_W + 4;
    localparam int SYN_RST = DATA_W + 5;
    localparam int SYN_TEST = DATA_W + 6; // three test pins from here upward
    // timing, in ns and in 10 ns cycles of mclk_i
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 60; // internal access time of one transfer
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ECLK_HIGH_NS = 150; // enable-clock high time driven by the host
    localparam int ECLK_HIGH_CYC = (ECLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_NS = 40; // host hold after a strobe is released
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    // reset values of the strobe pins (high) and the test pins (low)
    localparam logic PIN_IDLE_HIGH = 1'b1;
    localparam logic PIN_IDLE_LOW = 1'b0;
    typedef enum logic [2:0] {
        MODE_GENERIC = 3'b001,
        MODE_ASTROBE = 3'b010,
        MODE_ECLK = 3'b100
    } bus_mode_t;
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_BUSY = 3'b010,
        DEV_DONE = 3'b100
    } dev_state_t;
    typedef enum logic [3:0] {
        HST_IDLE = 4'b0001,
        HST_SETUP = 4'b0010,
        HST_STROBE = 4'b0100,
        HST_RECOVER = 4'b1000
    } hst_state_t;
endpackage

// >>> verilog/host_link_if.sv
// host port pins between the microprocessor bus and the display controller
`timescale 1ns/1ps
`default_nettype none
interface host_link_if;
    import host_bus_pkg::*;
    logic cs_n; // chip select
    logic as_n; // address strobe
    logic rd_n; // read strobe / enable clock / lower data strobe
    logic wr_n; // write strobe / read-write select
    logic a0; // register address line
    logic [DATA_W-1:0] hdata; // data driven by the host
    logic hdata_oe; // host drives the data bus
    logic [DATA_W-1:0] ddata; // data driven by the device
    logic ddata_oe; // device drives the data bus
    logic wack; // wait / acknowledge level
    logic wack_oe; // device drives wait / acknowledge
    logic reset_n; // hardware reset
    logic scan_test_enable; // reserved test input
    logic factory_test_enable; // reserved test input
    logic scan_input_enable; // reserved test input
    modport device (
        input cs_n, as_n, rd_n, wr_n, a0, hdata, hdata_oe, reset_n,
        input scan_test_enable, factory_test_enable, scan_input_enable,
        output ddata, ddata_oe, wack, wack_oe
    );
    modport host (
        output cs_n, as_n, rd_n, wr_n, a0, hdata, hdata_oe, reset_n,
        output scan_test_enable, factory_test_enable, scan_input_enable,
        input ddata, ddata_oe, wack, wack_oe
    );
endinterface
`default_nettype wire

// >>> verilog/host_port_device.sv
// display controller end of the host port: select, wait/acknowledge, reset, test pins
`timescale 1ns/1ps
`default_nettype none
module host_port_device (
    input wire logic mclk_i, // 100 MHz core clock
    input wire logic rst_i, // asynchronous reset, active high
    input wire host_bus_pkg::bus_mode_t mode_i, // strapped bus mode
    host_link_if.device link, // host pins
    output logic wr_valid_o, // one-cycle write pulse to the core
    output logic wr_addr_o, // address of that write
    output logic [host_bus_pkg::DATA_W-1:0] wr_data_o, // data of that write
    output logic rd_req_o, // one-cycle read request to the core
    output logic rd_addr_o, // address of that read
    input wire logic [host_bus_pkg::DATA_W-1:0] rd_data_i, // core read data, stable in access
    output logic in_reset_o, // hardware reset pin seen asserted
    output logic busy_o // a transfer is in progress
);
    import host_bus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: every pin is asynchronous to mclk_i
    logic [SYNC_W-1:0] pins_in;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic wr_n_prev_q;

    assign pins_in = {link.scan_input_enable, link.factory_test_enable,
                      link.scan_test_enable, link.reset_n, link.a0, link.wr_n,
                      link.rd_n, link.as_n, link.cs_n, link.hdata};

    // two stages; only the second is read by logic
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {SYNC_W{1'b1}} >> 3; // idle high pins, test pins low
            sync_q <= {SYNC_W{1'b1}} >> 3;
            wr_n_prev_q <= PIN_IDLE_HIGH;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            wr_n_prev_q <= sync_q[SYN_WR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded bus conditions
    logic hw_rst;
    logic test_on;
    logic sel;
    logic strobe;
    logic is_wr;
    logic wr_rise;
    logic busy_lvl;

    always_comb begin
        hw_rst = ~sync_q[SYN_RST];
        // test pins are expected low; a raised one leaves functional mode
        test_on = |sync_q[SYN_TEST +: 3];
        sel = ~sync_q[SYN_CS] & ~test_on & ~hw_rst;
        busy_lvl = (mode_i == MODE_ASTROBE);
        wr_rise = sync_q[SYN_WR] & ~wr_n_prev_q;
        unique case (mode_i)
            MODE_GENERIC: begin
                strobe = ~sync_q[SYN_RD] | ~sync_q[SYN_WR];
                is_wr = ~sync_q[SYN_WR];
            end
            MODE_ASTROBE: begin
                // address strobe qualifies the data strobe
                strobe = ~sync_q[SYN_AS] & ~sync_q[SYN_RD];
                is_wr = ~sync_q[SYN_WR];
            end
            MODE_ECLK: begin
                strobe = sync_q[SYN_RD];
                is_wr = ~sync_q[SYN_WR];
            end
            default: begin
                strobe = 1'b0;
                is_wr = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    dev_state_t state_q;
    dev_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic xfer_wr_q;
    logic xfer_wr_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        xfer_wr_d = xfer_wr_q;
        if (hw_rst) begin
            // a held reset pin keeps every sequencer register at its default
            state_d = DEV_IDLE;
            cnt_d = '0;
            xfer_wr_d = 1'b0;
        end else begin
            unique case (state_q)
                DEV_IDLE: begin
                    if (sel && strobe) begin
                        state_d = DEV_BUSY;
                        cnt_d = CNT_W'(ACCESS_CYC - 1);
                        xfer_wr_d = is_wr;
                    end
                end
                DEV_BUSY: begin
                    if (!sel || !strobe) begin
                        state_d = DEV_IDLE; // host gave up; drop the cycle
                    end else if (cnt_q == '0) begin
                        state_d = DEV_DONE;
                    end else begin
                        cnt_d = cnt_q - CNT_W'(1);
                    end
                end
                DEV_DONE: begin
                    // the done state, with its completion level driven outside enable-clock mode, holds until the host ends its strobe
                    if (!sel || !strobe) begin
                        state_d = DEV_IDLE;
                    end
                end
                default: state_d = DEV_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= DEV_IDLE;
            cnt_q <= '0;
            xfer_wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            xfer_wr_q <= xfer_wr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core side requests and returned read data
    logic wr_valid_d;
    logic wr_addr_d;
    logic [DATA_W-1:0] wr_data_d;
    logic rd_req_d;
    logic rd_addr_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic start;

    always_comb begin
        start = (state_q == DEV_IDLE) && sel && strobe && !hw_rst;
        wr_valid_d = 1'b0;
        wr_addr_d = wr_addr_o;
        wr_data_d = wr_data_o;
        rd_req_d = 1'b0;
        rd_addr_d = rd_addr_o;
        dout_d = dout_q;
        if (hw_rst) begin
            wr_addr_d = 1'b0;
            wr_data_d = '0;
            rd_addr_d = 1'b0;
            dout_d = '0;
        end else if (mode_i == MODE_GENERIC) begin
            // data is taken as the write strobe rises, never earlier
            if (sel && wr_rise) begin
                wr_valid_d = 1'b1;
                wr_addr_d = sync_q[SYN_A0];
                wr_data_d = sync_q[DATA_W-1:0];
            end
        end else if (start && is_wr) begin
            wr_valid_d = 1'b1;
            wr_addr_d = sync_q[SYN_A0];
            wr_data_d = sync_q[DATA_W-1:0];
        end
        if (start && !is_wr) begin
            rd_req_d = 1'b1;
            rd_addr_d = sync_q[SYN_A0];
        end
        if (state_q == DEV_BUSY && state_d == DEV_DONE && !xfer_wr_q) begin
            dout_d = rd_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_valid_o <= 1'b0;
            wr_addr_o <= 1'b0;
            wr_data_o <= '0;
            rd_req_o <= 1'b0;
            rd_addr_o <= 1'b0;
            dout_q <= '0;
        end else begin
            wr_valid_o <= wr_valid_d;
            wr_addr_o <= wr_addr_d;
            wr_data_o <= wr_data_d;
            rd_req_o <= rd_req_d;
            rd_addr_o <= rd_addr_d;
            dout_q <= dout_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wait / acknowledge pin, registered to avoid glitches on a shared line
    logic wack_q;
    logic wack_d;
    logic wack_oe_q;
    logic wack_oe_d;

    always_comb begin
        wack_d = 1'b1;
        wack_oe_d = 1'b0;
        if (hw_rst || !sel) begin
            wack_oe_d = 1'b0;
        end else if (mode_i == MODE_ECLK) begin
            wack_oe_d = 1'b0;
        end else if (state_d == DEV_BUSY) begin
            wack_oe_d = 1'b1;
            wack_d = busy_lvl;
        end else if (state_d == DEV_DONE) begin
            wack_oe_d = 1'b1;
            wack_d = ~busy_lvl;
        end else begin
            // back in idle: the pin floats again after completion
            wack_oe_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wack_q <= 1'b1;
            wack_oe_q <= 1'b0;
        end else begin
            wack_q <= wack_d;
            wack_oe_q <= wack_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin outputs
    always_comb begin
        link.wack = wack_q;
        link.wack_oe = wack_oe_q;
        link.ddata = dout_q;
        unique case (mode_i)
            MODE_GENERIC: link.ddata_oe = sel && !sync_q[SYN_RD];
            MODE_ASTROBE: link.ddata_oe = sel && strobe && !is_wr;
            MODE_ECLK: link.ddata_oe = sel && strobe && !is_wr;
            default: link.ddata_oe = 1'b0;
        endcase
        in_reset_o = hw_rst;
        busy_o = (state_q != DEV_IDLE);
    end
endmodule
`default_nettype wire

// >>> verilog/host_port_master.sv
// microprocessor bus end of the host port: runs one access per request
`timescale 1ns/1ps
`default_nettype none
module host_port_master (
    input wire logic mclk_i, // 100 MHz core clock
    input wire logic rst_i, // asynchronous reset, active high
    input wire host_bus_pkg::bus_mode_t mode_i, // bus mode, same strap as device
    host_link_if.host link, // device pins
    input wire logic req_i, // start an access (taken when ready_o)
    input wire logic req_we_i, // 1 write, 0 read
    input wire logic req_addr_i, // register address line
    input wire logic [host_bus_pkg::DATA_W-1:0] req_wdata_i, // write data
    input wire logic hw_reset_i, // hold device hardware reset
    output logic ready_o, // idle, a request may be made
    output logic done_o, // one-cycle pulse when an access ends
    output logic [host_bus_pkg::DATA_W-1:0] rdata_o // data of the last read
);
    import host_bus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // device pins are asynchronous: two stages before use
    logic [DATA_W+1:0] meta_q;
    logic [DATA_W+1:0] sync_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {link.wack_oe, link.wack, link.ddata};
            sync_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer
    hst_state_t state_q;
    hst_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic we_q;
    logic we_d;
    logic a0_q;
    logic a0_d;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic [DATA_W-1:0] rdata_d;
    logic done_d;
    logic rst_pin_q;
    logic ack_done;
    logic ack_free;

    always_comb begin
        // completion level depends on the mode; the enable-clock mode has none
        ack_done = sync_q[DATA_W+1] && (sync_q[DATA_W] == (mode_i == MODE_GENERIC));
        ack_free = !sync_q[DATA_W+1];
        state_d = state_q;
        cnt_d = cnt_q;
        we_d = we_q;
        a0_d = a0_q;
        wdata_d = wdata_q;
        rdata_d = rdata_o;
        done_d = 1'b0;
        unique case (state_q)
            HST_IDLE: begin
                if (req_i && !rst_pin_q) begin
                    state_d = HST_SETUP;
                    we_d = req_we_i;
                    a0_d = req_addr_i;
                    wdata_d = req_wdata_i;
                end
            end
            HST_SETUP: begin
                state_d = HST_STROBE;
                cnt_d = CNT_W'(ECLK_HIGH_CYC - 1);
            end
            HST_STROBE: begin
                if (mode_i == MODE_ECLK) begin
                    // no handshake: hold the enable clock for a fixed time
                    if (cnt_q == '0) begin
                        state_d = HST_RECOVER;
                        cnt_d = CNT_W'(HOLD_CYC - 1);
                        rdata_d = we_q ? rdata_o : sync_q[DATA_W-1:0];
                    end else begin
                        cnt_d = cnt_q - CNT_W'(1);
                    end
                end else if (ack_done) begin
                    state_d = HST_RECOVER;
                    cnt_d = CNT_W'(HOLD_CYC - 1);
                    rdata_d = we_q ? rdata_o : sync_q[DATA_W-1:0];
                end
            end
            HST_RECOVER: begin
                // wait out the hold time and the release of the shared line
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else if (mode_i == MODE_ECLK || ack_free) begin
                    state_d = HST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: state_d = HST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= HST_IDLE;
            cnt_q <= '0;
            we_q <= 1'b0;
            a0_q <= 1'b0;
            wdata_q <= '0;
            rdata_o <= '0;
            done_o <= 1'b0;
            rst_pin_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            we_q <= we_d;
            a0_q <= a0_d;
            wdata_q <= wdata_d;
            rdata_o <= rdata_d;
            done_o <= done_d;
            rst_pin_q <= hw_reset_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive derived from the sequencer state
    logic active;
    logic strobe_on;

    always_comb begin
        active = (state_q != HST_IDLE);
        strobe_on = (state_q == HST_STROBE);
        ready_o = !active && !rst_pin_q;
        link.cs_n = !active;
        link.a0 = a0_q;
        link.hdata = wdata_q;
        link.hdata_oe = active && we_q;
        link.reset_n = !rst_pin_q;
        // reserved test inputs held low for normal operation
        link.scan_test_enable = PIN_IDLE_LOW;
        link.factory_test_enable = PIN_IDLE_LOW;
        link.scan_input_enable = PIN_IDLE_LOW;
        link.as_n = PIN_IDLE_HIGH;
        unique case (mode_i)
            MODE_GENERIC: begin
                link.rd_n = !(strobe_on && !we_q);
                link.wr_n = !(strobe_on && we_q);
            end
            MODE_ASTROBE: begin
                link.as_n = !strobe_on;
                link.rd_n = !strobe_on;
                link.wr_n = !(active && we_q);
            end
            MODE_ECLK: begin
                link.rd_n = strobe_on;
                link.wr_n = !(active && we_q);
            end
            default: begin
                link.rd_n = PIN_IDLE_HIGH;
                link.wr_n = PIN_IDLE_HIGH;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/host_port_monitor.sv
// concurrent checks on the host port pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor (
    input wire logic mclk_i, // core clock
    input wire logic rst_i, // asynchronous reset, active high
    input wire host_bus_pkg::bus_mode_t mode_i, // strapped bus mode
    input wire logic cs_n, // chip select
    input wire logic as_n, // address strobe
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    input wire logic hdata_oe, // host drives data
    input wire logic ddata_oe, // device drives data
    input wire logic wack, // wait / acknowledge level
    input wire logic wack_oe, // device drives wait / acknowledge
    input wire logic reset_n, // hardware reset
    input wire logic scan_test_enable, // reserved test input
    input wire logic factory_test_enable, // reserved test input
    input wire logic scan_input_enable // reserved test input
);
    import host_bus_pkg::*;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // pins pass a two-flop synchroniser, so each idle window allows for that lag
    wack_deselect_a: assert property (cs_n [*5] |-> !wack_oe)
        else $error("wait pin driven while deselected");
    generic_wait_a: assert property ((mode_i == MODE_GENERIC) && $rose(wack_oe) |->
        !wack ##[1:10] (wack && wack_oe))
        else $error("generic wait level or completion wrong");
    generic_release_a: assert property (((mode_i == MODE_GENERIC) && rd_n && wr_n) [*4]
        |-> !wack_oe)
        else $error("generic wait not released");
    astrobe_ack_a: assert property ((mode_i == MODE_ASTROBE) && $rose(wack_oe) |->
        wack ##[1:10] (!wack && wack_oe))
        else $error("acknowledge level or completion wrong");
    astrobe_release_a: assert property (((mode_i == MODE_ASTROBE) && rd_n) [*4]
        |-> !wack_oe)
        else $error("acknowledge not released");
    eclk_float_a: assert property ((mode_i == MODE_ECLK) |-> !wack_oe)
        else $error("wait pin driven in enable-clock mode");
    astrobe_qual_a: assert property (((mode_i == MODE_ASTROBE) && as_n) [*5]
        |-> !$rose(wack_oe))
        else $error("cycle started without address strobe");
    generic_rdoe_a: assert property (((mode_i == MODE_GENERIC) && rd_n) [*4]
        |-> !ddata_oe)
        else $error("data driven without read strobe");
    // both ends must never drive the shared data lines at once
    bus_clash_a: assert property (!(hdata_oe && ddata_oe))
        else $error("both ends drive the data bus");
    hw_reset_out_a: assert property (!reset_n [*4] |-> !wack_oe && !ddata_oe)
        else $error("outputs active in hardware reset");
    test_pins_a: assert property (!scan_test_enable && !factory_test_enable
        && !scan_input_enable)
        else $error("test input raised");
    // main scenarios reached
    generic_cov: cover property ((mode_i == MODE_GENERIC) && $rose(wack_oe));
    astrobe_cov: cover property ((mode_i == MODE_ASTROBE) && $fell(wack));
    reset_cov: cover property ($fell(reset_n));
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench joining the host end and the device end of the port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import host_bus_pkg::*;
    logic mclk_i, rst_i, req_i, req_we_i, req_addr_i, hw_reset_i;
    logic ready_o, done_o, wr_valid_o, wr_addr_o, rd_req_o, rd_addr_o, in_reset_o, busy_o;
    logic [DATA_W-1:0] req_wdata_i, rdata_o, wr_data_o, rd_data_i, wr_last;
    logic wa_last, ra_last;
    bus_mode_t mode;
    int num_errors, total_checks, wr_seen, rd_seen;
    bus_mode_t modes [3] = '{MODE_GENERIC, MODE_ASTROBE, MODE_ECLK};
    host_link_if link ();
    host_port_device host_port_device_i (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
        .link(link.device), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
        .rd_data_i(rd_data_i), .in_reset_o(in_reset_o), .busy_o(busy_o));
    host_port_master host_port_master_i (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
        .link(link.host), .req_i(req_i), .req_we_i(req_we_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .hw_reset_i(hw_reset_i), .ready_o(ready_o),
        .done_o(done_o), .rdata_o(rdata_o));
    host_port_monitor monitor_i (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
        .cs_n(link.cs_n), .as_n(link.as_n), .rd_n(link.rd_n), .wr_n(link.wr_n),
        .hdata_oe(link.hdata_oe), .ddata_oe(link.ddata_oe), .wack(link.wack),
        .wack_oe(link.wack_oe),
        .reset_n(link.reset_n), .scan_test_enable(link.scan_test_enable),
        .factory_test_enable(link.factory_test_enable),
        .scan_input_enable(link.scan_input_enable));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, and a record of what the device hands to its core
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // one-cycle pulses are looked at mid-cycle, clear of the edge that launches them
    always @(negedge mclk_i) begin
        if (wr_valid_o === 1'b1) begin
            wr_seen++;
            wr_last = wr_data_o;
            wa_last = wr_addr_o;
        end
        if (rd_req_o === 1'b1) begin
            rd_seen++;
            ra_last = rd_addr_o;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        num_errors++;
        $display("FAIL at %0t: %s", $time, msg);
    endtask
    task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // mode is only a strap, so it changes under reset
    task automatic do_reset(input bus_mode_t m);
        rst_i = 1'b1;
        mode = m;
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
    endtask
    // one access through the host end; request held until the taking edge
    task automatic access(input logic we, input logic addr, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        req_i = 1'b1;
        req_we_i = we;
        req_addr_i = addr;
        req_wdata_i = d;
        @(negedge mclk_i);
        req_i = 1'b0;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (done_o !== 1'b1 && n < 300);
        if (n >= 300) fail("access never completed");
        @(negedge mclk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        total_checks = 0;
        wr_seen = 0;
        rd_seen = 0;
        req_i = 1'b0;
        req_we_i = 1'b0;
        req_addr_i = 1'b0;
        req_wdata_i = 8'h00;
        hw_reset_i = 1'b0;
        rd_data_i = 8'h00;
        mode = MODE_GENERIC;
        rst_i = 1'b1;
        // writes back to back, then a read, in every bus mode
        foreach (modes[i]) begin
            do_reset(modes[i]);
            access(1'b1, 1'b1, 8'h5a + 8'(i));
            chk_bit(wa_last, 1'b1);
            chk_data(wr_last, 8'h5a + 8'(i));
            access(1'b1, 1'b0, 8'ha5);
            chk_bit(wa_last, 1'b0);
            chk_data(wr_last, 8'ha5);
            chk_data(8'(wr_seen), 8'(2 * (i + 1)));
            rd_data_i = 8'h3c ^ 8'(i);
            access(1'b0, 1'b1, 8'h00);
            chk_data(rdata_o, 8'h3c ^ 8'(i));
            chk_data(8'(rd_seen), 8'(i + 1));
            chk_bit(ra_last, 1'b1);
            chk_bit(link.wack_oe, 1'b0);
            $display("test mode %0d done", i);
        end
        // hardware reset after a write clears state and quiets the outputs
        do_reset(MODE_GENERIC);
        access(1'b1, 1'b1, 8'hc3);
        hw_reset_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        chk_bit(in_reset_o, 1'b1);
        chk_data(wr_data_o, 8'h00);
        chk_bit(wr_addr_o, 1'b0);
        chk_bit(busy_o, 1'b0);
        chk_bit(link.wack_oe, 1'b0);
        chk_bit(link.ddata_oe, 1'b0);
        hw_reset_i = 1'b0;
        access(1'b1, 1'b0, 8'h81);
        chk_data(wr_last, 8'h81);
        chk_bit(in_reset_o, 1'b0);
        $display("test hardware reset done");
        complete_run();
    end
    // watchdog well beyond the few hundred cycles each access may take
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail("watchdog expired");
        complete_run();
    end
endmodule
`default_nettype wire
